//--- hw/srx_pkg.sv
package srx_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned STS1_BYTE_HZ    = 6_480_000;
	localparam int unsigned STS3C_BYTE_HZ   = 19_440_000;
	localparam int unsigned STS12C_BYTE_HZ  = 77_760_000;
	localparam int unsigned SERIAL_CLK_HZ   = 51_840_000;

	// serial clock edges per byte, and edges the derived clock stays high
	localparam int unsigned SER_DIV         = 8;
	localparam int unsigned SER_HIGH        = SER_DIV / 2;
	localparam int unsigned SER_CNT_W       = $clog2(SER_DIV);

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  BYTE_RST        = 8'h00;
	localparam logic [2:0]  SER_CNT_RST     = 3'h0;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRX_MODE_STS1,
		SRX_MODE_STS3C,
		SRX_MODE_STS12C
	} srx_mode_t;

	// one captured line byte and the frame position it carries
	typedef struct packed {
		logic [7:0] data;
		logic       mark_a2;    // third a2 framing byte
		logic       mark_spe;   // first envelope byte after c1
	} srx_word_t;

	localparam srx_word_t WORD_RST = '{data: BYTE_RST, mark_a2: 1'b0, mark_spe: 1'b0};

endpackage

//--- hw/srx_line_capture.sv
// How it works
// - receive processing is timed by each rising edge of the line byte clock
// - frame marker pulse, and line data outside serial mode, are sampled on the line byte clock rise
// - data bit 7 is the first serial bit received, bit 0 the last
// - sts-3c/12c with select high: marker flags the third a2 byte
// - sts-3c/12c with select low: marker flags first envelope byte after c1
// - sts-1: marker always flags first envelope byte after c1
// - in serial mode, serial data is sampled on each rising serial clock edge
// - in serial mode the derived byte clock is serial clock divided by eight
// - derived byte clock changes on serial clock rise and feeds the line byte clock

module srx_line_capture (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// configuration
	input  wire srx_pkg::srx_mode_t mode,
	input  wire logic              serial_mode,
	input  wire logic              frame_marker_select,
	// byte-serial line
	input  wire logic              line_byte_clock,
	input  wire logic [7:0]        line_data,
	input  wire logic              frame_marker_pulse,
	// bit-serial line
	input  wire logic              serial_rx_clock,
	input  wire logic              serial_rx_data,
	output logic                   derived_rx_byte_clock,
	// captured stream
	output srx_pkg::srx_word_t     out_word,
	output logic                   out_valid,
	input  wire logic              out_ready,
	// flow status
	output logic                   line_ready,
	output logic                   overrun
);

	// ----------------------------------------------------------------
	// edge detection on the line-side clocks
	// ----------------------------------------------------------------
	logic                          byte_clk_prev_r;
	logic                          ser_clk_prev_r;
	wire logic                     byte_rise;
	wire logic                     ser_rise;

	// pins are taken as synchronous, so one history flop is enough
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			byte_clk_prev_r <= 1'b0;
			ser_clk_prev_r  <= 1'b0;
		end else begin
			byte_clk_prev_r <= line_byte_clock;
			ser_clk_prev_r  <= serial_rx_clock;
		end
	end

	assign byte_rise = line_byte_clock & ~byte_clk_prev_r;
	// a stopped serial clock gives no edges, so the divider simply holds
	assign ser_rise  = serial_mode & serial_rx_clock & ~ser_clk_prev_r;

	// ----------------------------------------------------------------
	// bit-serial assembly and byte clock divider
	// ----------------------------------------------------------------
	logic [srx_pkg::SER_CNT_W-1:0] ser_cnt_r;
	logic [7:0]                    ser_shift_r;
	logic [7:0]                    ser_byte_r;
	wire logic [7:0]               ser_shift_nxt;
	wire logic                     ser_last;
	wire logic                     div_high_nxt;

	assign ser_shift_nxt = {ser_shift_r[6:0], serial_rx_data};
	assign ser_last      = (ser_cnt_r == srx_pkg::SER_CNT_W'(srx_pkg::SER_DIV - 1));
	// high for the first half of the eight-bit group, low for the second
	assign div_high_nxt  = ser_last
	                     | (ser_cnt_r < srx_pkg::SER_CNT_W'(srx_pkg::SER_HIGH - 1));

	// the finished byte is held so the fed-back clock can capture it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ser_cnt_r             <= srx_pkg::SER_CNT_RST;
			ser_shift_r           <= srx_pkg::BYTE_RST;
			ser_byte_r            <= srx_pkg::BYTE_RST;
			derived_rx_byte_clock <= 1'b0;
		end else if (ser_rise) begin
			ser_cnt_r             <= ser_cnt_r + 1'b1;
			ser_shift_r           <= ser_shift_nxt;
			derived_rx_byte_clock <= div_high_nxt;
			if (ser_last) begin
				ser_byte_r <= ser_shift_nxt;
			end
		end
	end

	// ----------------------------------------------------------------
	// byte capture and frame position decode
	// ----------------------------------------------------------------
	wire logic                     mode_sts1;
	wire logic                     mark_a2;
	wire logic                     mark_spe;
	wire srx_pkg::srx_word_t       cap_word;

	assign mode_sts1 = (mode == srx_pkg::SRX_MODE_STS1);
	// select only matters at the higher rates; sts-1 always marks the envelope
	assign mark_a2   = frame_marker_pulse & ~mode_sts1 & frame_marker_select;
	assign mark_spe  = frame_marker_pulse & (mode_sts1 | ~frame_marker_select);

	// serial mode takes the assembled byte on the fed-back byte clock
	assign cap_word.data     = serial_mode ? ser_byte_r : line_data;
	assign cap_word.mark_a2  = mark_a2;
	assign cap_word.mark_spe = mark_spe;

	// ----------------------------------------------------------------
	// two-entry buffer: head drives the outputs, skid absorbs one stall
	// ----------------------------------------------------------------
	srx_pkg::srx_word_t            skid_r;
	logic                          skid_v_r;
	srx_pkg::srx_word_t            head_nxt;
	srx_pkg::srx_word_t            skid_nxt;
	logic                          head_v_nxt;
	logic                          skid_v_nxt;
	wire logic                     push;
	wire logic                     pop;

	// the line cannot be held off, so a word arriving when full is lost
	assign push = byte_rise & ~(out_valid & skid_v_r);
	assign pop  = out_valid & out_ready;

	always_comb begin
		head_nxt   = out_word;
		head_v_nxt = out_valid;
		skid_nxt   = skid_r;
		skid_v_nxt = skid_v_r;
		if (pop && skid_v_r) begin
			head_nxt = skid_r;
			if (push) begin
				skid_nxt = cap_word;
			end else begin
				skid_v_nxt = 1'b0;
			end
		end else if (pop) begin
			head_nxt   = cap_word;
			head_v_nxt = push;
		end else if (push && !out_valid) begin
			head_nxt   = cap_word;
			head_v_nxt = 1'b1;
		end else if (push) begin
			skid_nxt   = cap_word;
			skid_v_nxt = 1'b1;
		end
	end

	// buffer state and the registered flow flags
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_word   <= srx_pkg::WORD_RST;
			out_valid  <= 1'b0;
			skid_r     <= srx_pkg::WORD_RST;
			skid_v_r   <= 1'b0;
			line_ready <= 1'b0;
			overrun    <= 1'b0;
		end else begin
			out_word   <= head_nxt;
			out_valid  <= head_v_nxt;
			skid_r     <= skid_nxt;
			skid_v_r   <= skid_v_nxt;
			line_ready <= ~(head_v_nxt & skid_v_nxt);
			overrun    <= overrun | (byte_rise & ~push);                   // sticky until reset
		end
	end

endmodule

//--- verification/srx_cap_chk_asserts.sv
module srx_cap_chk (
	// clock, reset and configuration
	input wire logic               clk, sys_rst, serial_mode, frame_marker_select,
	input wire srx_pkg::srx_mode_t mode,
	// line inputs
	input wire logic               line_byte_clock, frame_marker_pulse, serial_rx_clock,
	input wire logic [7:0]         line_data,
	// design outputs and the out_ready input
	input wire logic               derived_rx_byte_clock, out_valid, out_ready, overrun,
	input wire srx_pkg::srx_word_t out_word
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// edge history, cleared like the design's
	// ----------------------------------------
	logic       lbc_r, sck_r, any_r;
	logic [2:0] n_r;
	wire        cap    = line_byte_clock & ~lbc_r & ~out_valid & ~serial_mode;
	wire        srise  = serial_mode & serial_rx_clock & ~sck_r;
	wire        sts1   = mode == srx_pkg::SRX_MODE_STS1;
	wire        a2_exp = frame_marker_pulse & ~sts1 & frame_marker_select;
	wire        sp_exp = frame_marker_pulse & (sts1 | ~frame_marker_select);
	// serial rises counted modulo eight, as the divider groups them
	always_ff @(posedge clk) begin
		lbc_r <= ~sys_rst & line_byte_clock;
		sck_r <= ~sys_rst & serial_rx_clock;
		n_r   <= sys_rst ? 3'h0 : n_r + 3'(srise);
		any_r <= ~sys_rst & (any_r | srise);
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	rst_clear_a: assert property ($fell(sys_rst) |-> !out_valid && !overrun && !derived_rx_byte_clock)
		else $error("outputs not clear after reset");
	cap_data_a: assert property (cap |=> out_valid && out_word.data == $past(line_data))
		else $error("captured byte wrong");
	mark_a2_a: assert property (cap |=> out_word.mark_a2 == $past(a2_exp))
		else $error("a2 marker wrong");
	mark_spe_a: assert property (cap |=> out_word.mark_spe == $past(sp_exp))
		else $error("envelope marker wrong");
	hold_word_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
		else $error("word not held");
	ovr_sticky_a: assert property (overrun |=> overrun)
		else $error("overrun dropped");
	div_eight_a: assert property (derived_rx_byte_clock == (any_r & ~n_r[2]))
		else $error("divided clock phase wrong");
	div_edge_a: assert property ($changed(derived_rx_byte_clock) |-> $past(srise))
		else $error("divided clock moved off a serial rise");
endmodule

bind srx_line_capture srx_cap_chk chk (.*);

//--- verification/srx_cdr_model.sv
module srx_cdr_model (
	// clock
	input wire logic   clk,
	// line side
	output logic       line_byte_clock, frame_marker_pulse, serial_rx_clock, serial_rx_data,
	output logic [7:0] line_data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {line_byte_clock, frame_marker_pulse, serial_rx_clock, serial_rx_data, line_data} = 12'h000;
	// one byte per rise; data turns over once the high phase ends, so stale bytes show
	task automatic send_byte(input logic [7:0] d, input logic fp);
		@(posedge clk) #1;
		{line_byte_clock, line_data, frame_marker_pulse} = {1'b1, d, fp};
		@(posedge clk) #1;
		{line_byte_clock, line_data, frame_marker_pulse} = {1'b0, ~d, 1'b0};
	endtask
	// slow serial clock, first bit first; it stands low between bytes
	task automatic send_bits(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk) #1;
			{serial_rx_clock, serial_rx_data} = {1'b1, d[i]};
			repeat (2) @(posedge clk);
			#1 {serial_rx_clock, serial_rx_data} = {1'b0, ~d[i]};
			@(posedge clk);
		end
	endtask
endmodule

//--- verification/tb_srx_line_capture.sv
module tb_srx_line_capture;
	timeunit 1ns;
	timeprecision 1ns;
	logic               clk = 1'b0, sys_rst = 1'b1, serial_mode = 1'b0, frame_marker_select = 1'b0;
	logic               out_ready = 1'b1, lbc, frame_marker_pulse, serial_rx_clock, serial_rx_data;
	logic               dclk, out_valid, line_ready, overrun;
	logic [7:0]         line_data;
	srx_pkg::srx_mode_t mode = srx_pkg::SRX_MODE_STS1;
	srx_pkg::srx_word_t out_word, got[$];
	int                 num_errors = 0, check_count = 0;
	// rows: mode, select, pulse, then the word expected
	logic [13:0]        rows [6] = '{14'h0E01, 14'h0405, 14'h1E96, 14'h1569, 14'h2FFE, 14'h20F0};
	always #25 clk = ~clk;
	srx_cdr_model p (.line_byte_clock(lbc), .*);
	// serial mode loops the divided clock back as the byte clock
	srx_line_capture uut (.line_byte_clock(serial_mode ? dclk : lbc), .derived_rx_byte_clock(dclk), .*);
	// every popped word is kept for the checks
	always @(posedge clk) if (out_valid === 1'b1 && out_ready) got.push_back(out_word);
	task automatic check(input logic ok, input string what);
		check_count++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("FAIL %0t %s", $time, what);
		end
	endtask
	task automatic tally_and_finish;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// tests take about 160 cycles, so this only trips on a hang
	initial begin
		repeat (4000) @(posedge clk);
		num_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (20) @(posedge clk);
		#1 sys_rst = 1'b0;
		@(posedge clk) #1;
		check(out_valid === 1'b0 && overrun === 1'b0 && dclk === 1'b0 && line_ready === 1'b1, "reset");
		foreach (rows[i]) begin
			#1 mode = srx_pkg::srx_mode_t'(rows[i][13:12]);
			frame_marker_select = rows[i][11];
			p.send_byte(rows[i][9:2], rows[i][10]);
			repeat (3) @(posedge clk);
			check(got.size() == 1 && got.pop_front() === rows[i][9:0], "row word");
			got.delete();
		end
		// stalled receiver: two words fit, the third is lost
		#1 out_ready = 1'b0;
		for (int k = 1; k < 4; k++) p.send_byte(8'(k), 1'b0);
		@(posedge clk) #1;
		check(overrun === 1'b1 && line_ready === 1'b0, "overrun");
		out_ready = 1'b1;
		repeat (3) @(posedge clk);
		check(got.size() == 2 && got[0].data === 8'h01 && got[1].data === 8'h02, "kept words");
		got.delete();
		p.send_bits(8'hA5);
		check(got.size() == 0 && dclk === 1'b0, "serial ignored");
		#1 serial_mode = 1'b1;
		mode = srx_pkg::SRX_MODE_STS1;
		p.send_bits(8'hC3);
		p.send_bits(8'h96);
		repeat (4) @(posedge clk);
		check(got.size() >= 2 && got[got.size()-2].data === 8'hC3 && got[got.size()-1].data === 8'h96, "serial");
		tally_and_finish;
	end
endmodule
